// ---- src/dma_channel_pkg.sv ----
/*
 * Shared constants for the DMA channel control block.
 * Assumes a single clock domain and plain-port control from software.
 */
package dma_channel_pkg;
   localparam int NUM_CHANNELS = 4;
   localparam int CHAN_W = 2;
   localparam int SOFTWARE_ONLY_CHANNEL = 3;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int COUNT_W = 11;
   localparam int ARB_W = 4;
   localparam int ARB_MAX_LOG2 = 10;
   localparam int FIFO_DEPTH = 32;
   localparam int TASK_WORDS = 4;
   localparam int MODE_W = 3;
   localparam logic [2:0] MODE_STOPPED = 3'h0;
   localparam logic [2:0] MODE_BASIC_REQUEST = 3'h1;
   localparam logic [2:0] MODE_AUTO_COMPLETE = 3'h2;
   localparam logic [2:0] MODE_PING_PONG = 3'h3;
   localparam logic [2:0] MODE_MEMORY_SCATTER_GATHER = 3'h4;
   localparam logic [2:0] MODE_PERIPHERAL_SCATTER_GATHER = 3'h6;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [1:0] ATTR_RESET = 2'h0;
endpackage

// ---- src/dma_fifo.sv ----
/*
 * Parameterised synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; reader may stall so the FIFO genuinely fills.
 */
`timescale 1ns/1ps
module dma_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ---- src/dma_channel_control.sv ----
/*
 * Per-channel DMA control: enables, modes, attributes, requests, completion.
 * Assumes a memory side that accepts reads and writes with a ready handshake
 * and returns read data a cycle after an accepted read.
 */
//
// Contract
// R01: A disabled channel services no requests and moves no data; a channel disabled mid-run still finishes its current arbitration run.
// R02: Completion clears the channel enable without software action.
// R03: Software must re-enable the channel before each new transfer.
// R04: Each channel's enable state is readable by software.
// R05: Mode of each control structure is readable; reads stop after completion.
// R06: Mode is stop, basic, auto, ping-pong, memory or peripheral scatter-gather.
// R07: Primary and alternate structures per channel, selected with channel number.
// R08: Software request starts a transfer without peripheral request.
// R09: Software-only channel completion pulses the dedicated interrupt.
// R10: Peripheral channel completion pulses that peripheral's completion line.
// R11: Scatter-gather set up from task list start, task count and flag.
// R12: Four attributes per channel: burst only, alternate, priority, request mask.
// R13: Arbitration size 1 to 1024 items in powers of two.
// R14: Auto mode runs to completion even if request is withdrawn.
// R15: Enable clears in the same cycle the mode becomes stop.
`timescale 1ns/1ps
module dma_channel_control (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Channel control.
   input wire logic [3:0] enable_set,
   input wire logic [3:0] enable_clear,
   output logic [3:0] enable_status,
   input wire logic [3:0] software_request,
   input wire logic [3:0] peripheral_request,
   // Attribute access.
   input wire logic [1:0] attr_channel,
   input wire logic attr_write,
   input wire logic [3:0] attr_value,
   output logic [3:0] attr_readback,
   // Control structure setup.
   input wire logic setup_write,
   input wire logic [1:0] setup_channel,
   input wire logic alternate_structure_select,
   input wire logic [2:0] setup_mode,
   input wire logic [31:0] setup_src,
   input wire logic [31:0] setup_dst,
   input wire logic [10:0] setup_count,
   input wire logic [3:0] setup_arb_log2,
   // Scatter-gather setup.
   input wire logic sg_write,
   input wire logic [31:0] task_list_start,
   input wire logic [10:0] scatter_gather_task_count,
   input wire logic peripheral_scatter_gather_flag,
   // Mode readback.
   input wire logic [1:0] mode_channel,
   input wire logic mode_alternate,
   output logic [2:0] mode_readback,
   // Completion.
   output logic done_interrupt,
   output logic [3:0] peripheral_done,
   // Memory side.
   output logic mem_valid,
   output logic mem_write,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata,
   output logic arb_release
);
   typedef enum logic [2:0] {ST_IDLE, ST_TASK, ST_READ, ST_WAIT, ST_WRITE} state_e;
   localparam int NC = dma_channel_pkg::NUM_CHANNELS;
   localparam int DW = dma_channel_pkg::DATA_W;
   // ****************************************
   // Channel state
   // ****************************************
   logic [NC-1:0] en_q;
   logic [NC-1:0] pend_q;
   logic [NC-1:0] burst_q, alt_q, prio_q, mask_q;
   logic [2:0] mode_q [NC][2];
   logic [31:0] src_q [NC][2];
   logic [31:0] dst_q [NC][2];
   logic [10:0] cnt_q [NC][2];
   logic [3:0] arb_q [NC][2];
   logic [NC-1:0] preq_s1_q, preq_s2_q;
   state_e st_q;
   logic [1:0] ch_q;
   logic sel_q;
   logic [10:0] arb_cnt_q;
   logic [1:0] tw_q;
   logic [31:0] task_ptr_q;
   logic [NC-1:0] done_q;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
   logic [DW-1:0] fifo_out_data;
   logic [NC-1:0] live_req;
   logic pick_valid;
   logic [1:0] pick_ch;
   logic finish;
   logic chan_done;
   logic task_take_q;
   logic [1:0] task_idx_q;
   logic [2:0] cur_mode;
   // Peripheral request lines come from another block's pins; synchronise them.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         preq_s1_q <= '0;
         preq_s2_q <= '0;
      end else begin
         preq_s1_q <= peripheral_request;
         preq_s2_q <= preq_s1_q;
      end
   end
   // Requests latch while enabled; masked peripheral requests are ignored.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= '0;
      end else begin
         for (int i = 0; i < NC; i++) begin
            if (!en_q[i]) begin
               pend_q[i] <= 1'b0; // R01
            end else if (software_request[i] || (preq_s2_q[i] && !mask_q[i])) begin
               pend_q[i] <= 1'b1; // R08 R12
            end else if (st_q == ST_WRITE && mem_ready && fifo_out_valid && !finish
               && ch_q == 2'(i) && cur_mode == dma_channel_pkg::MODE_AUTO_COMPLETE) begin
               pend_q[i] <= 1'b1; // R14
            end else if (st_q == ST_IDLE && pick_valid && pick_ch == 2'(i)) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end
   assign live_req = pend_q & en_q;
   // ****************************************
   // Arbitration: high priority first, then lowest number
   // ****************************************
   always_comb begin
      pick_valid = 1'b0;
      pick_ch = '0;
      for (int i = NC - 1; i >= 0; i--) begin
         if (live_req[i] && !prio_q[i]) begin
            pick_valid = 1'b1;
            pick_ch = 2'(i);
         end
      end
      for (int i = NC - 1; i >= 0; i--) begin
         if (live_req[i] && prio_q[i]) begin
            pick_valid = 1'b1;
            pick_ch = 2'(i);
         end
      end
   end
   assign cur_mode = mode_q[ch_q][sel_q];
   assign finish = (st_q == ST_WRITE) && mem_ready && (cnt_q[ch_q][sel_q] == 11'h001);
   assign chan_done = finish && (!(sel_q && mode_q[ch_q][0][2]) || cnt_q[ch_q][0] == 11'h001);
   // ****************************************
   // Transfer engine
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         ch_q <= '0;
         sel_q <= 1'b0;
         arb_cnt_q <= '0;
         tw_q <= '0;
         task_ptr_q <= '0;
         task_take_q <= 1'b0;
         task_idx_q <= '0;
      end else begin
         task_take_q <= (st_q == ST_TASK) && mem_ready;
         task_idx_q <= tw_q;
         unique case (st_q)
            ST_IDLE: begin
               if (pick_valid) begin
                  ch_q <= pick_ch;
                  sel_q <= alt_q[pick_ch]; // R07
                  arb_cnt_q <= '0;
                  st_q <= (mode_q[pick_ch][alt_q[pick_ch]] == MODE_SG_ANY(pick_ch))
                     ? ST_TASK : ST_READ;
               end
            end
            ST_TASK: begin
               // Scatter-gather: the primary structure walks the task list. R11
               if (mem_ready) begin
                  tw_q <= tw_q + 2'h1;
                  if (tw_q == 2'h3) begin
                     task_ptr_q <= task_ptr_q + 32'h10;
                     sel_q <= 1'b1;
                     st_q <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (mem_ready && fifo_in_ready) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               st_q <= ST_WRITE;
            end
            ST_WRITE: begin
               if (mem_ready && fifo_out_valid) begin
                  arb_cnt_q <= arb_cnt_q + 11'h001;
                  if (cnt_q[ch_q][sel_q] == 11'h001) begin
                     st_q <= ST_IDLE;
                  end else if (arb_cnt_q + 11'h001 == (11'h001 << arb_q[ch_q][sel_q])) begin
                     st_q <= ST_IDLE; // R13
                  end else begin
                     st_q <= ST_READ; // R14
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   function automatic logic [2:0] MODE_SG_ANY(input logic [1:0] c);
      MODE_SG_ANY = mode_q[c][0][2] ? mode_q[c][0] : 3'h7;
   endfunction
   // Enable: set by software, cleared by software or by completion.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         en_q <= '0;
      end else begin
         for (int i = 0; i < NC; i++) begin
            if (chan_done && ch_q == 2'(i)) begin
               en_q[i] <= 1'b0; // R02 R15
            end else if (enable_set[i]) begin
               en_q[i] <= 1'b1;
            end else if (enable_clear[i]) begin
               en_q[i] <= 1'b0;
            end
         end
      end
   end
   // ****************************************
   // Control structures and attributes
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NC; i++) begin
            for (int s = 0; s < 2; s++) begin
               mode_q[i][s] <= dma_channel_pkg::MODE_RESET;
               src_q[i][s] <= '0;
               dst_q[i][s] <= '0;
               cnt_q[i][s] <= '0;
               arb_q[i][s] <= '0;
            end
         end
      end else begin
         if (task_take_q && task_idx_q == 2'h0) begin
            src_q[ch_q][1] <= mem_rdata; // R11
         end else if (task_take_q && task_idx_q == 2'h1) begin
            dst_q[ch_q][1] <= mem_rdata;
         end else if (task_take_q && task_idx_q == 2'h2) begin
            cnt_q[ch_q][1] <= mem_rdata[10:0];
            mode_q[ch_q][1] <= dma_channel_pkg::MODE_BASIC_REQUEST;
         end
         if (st_q == ST_WRITE && mem_ready && fifo_out_valid) begin
            src_q[ch_q][sel_q] <= src_q[ch_q][sel_q] + 32'h4;
            dst_q[ch_q][sel_q] <= dst_q[ch_q][sel_q] + 32'h4;
            cnt_q[ch_q][sel_q] <= cnt_q[ch_q][sel_q] - 11'h001;
            if (finish) begin
               mode_q[ch_q][sel_q] <= dma_channel_pkg::MODE_STOPPED; // R05 R15
               if (sel_q && mode_q[ch_q][0][2]) begin
                  cnt_q[ch_q][0] <= cnt_q[ch_q][0] - 11'h001;
                  if (cnt_q[ch_q][0] == 11'h001) begin
                     mode_q[ch_q][0] <= dma_channel_pkg::MODE_STOPPED;
                  end
               end
            end
         end
         if (setup_write) begin
            mode_q[setup_channel][alternate_structure_select] <= setup_mode; // R06 R07
            src_q[setup_channel][alternate_structure_select] <= setup_src;
            dst_q[setup_channel][alternate_structure_select] <= setup_dst;
            cnt_q[setup_channel][alternate_structure_select] <= setup_count;
            arb_q[setup_channel][alternate_structure_select] <=
               (setup_arb_log2 > 4'hA) ? 4'hA : setup_arb_log2; // R13
         end
         if (sg_write) begin
            mode_q[setup_channel][0] <= peripheral_scatter_gather_flag ?
               dma_channel_pkg::MODE_PERIPHERAL_SCATTER_GATHER :
               dma_channel_pkg::MODE_MEMORY_SCATTER_GATHER; // R11
            src_q[setup_channel][0] <= task_list_start;
            cnt_q[setup_channel][0] <= scatter_gather_task_count;
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         burst_q <= '0;
         alt_q <= '0;
         prio_q <= '0;
         mask_q <= '0;
      end else if (attr_write) begin
         burst_q[attr_channel] <= attr_value[0]; // R12
         alt_q[attr_channel] <= attr_value[1];
         prio_q[attr_channel] <= attr_value[2];
         mask_q[attr_channel] <= attr_value[3];
      end
   end
   // ****************************************
   // Completion signalling
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         done_q <= '0;
      end else begin
         done_q <= '0;
         if (chan_done) begin
            done_q[ch_q] <= 1'b1;
         end
      end
   end
   assign done_interrupt = done_q[dma_channel_pkg::SOFTWARE_ONLY_CHANNEL]; // R09
   assign peripheral_done = done_q & ~(4'h1 << dma_channel_pkg::SOFTWARE_ONLY_CHANNEL); // R10
   // ****************************************
   // Data path and readback
   // ****************************************
   assign fifo_in_valid = (st_q == ST_WAIT);
   assign mem_valid = (st_q == ST_TASK) || (st_q == ST_READ && fifo_in_ready)
      || (st_q == ST_WRITE && fifo_out_valid);
   assign mem_write = (st_q == ST_WRITE);
   assign mem_addr = (st_q == ST_TASK) ? (src_q[ch_q][0] + task_ptr_q + {28'h0, tw_q, 2'h0})
      : (st_q == ST_WRITE) ? dst_q[ch_q][sel_q] : src_q[ch_q][sel_q];
   assign mem_wdata = fifo_out_data;
   assign arb_release = (st_q == ST_WRITE) && mem_ready && fifo_out_valid;
   assign enable_status = en_q; // R04
   assign mode_readback = mode_q[mode_channel][mode_alternate]; // R05
   assign attr_readback = {mask_q[attr_channel], prio_q[attr_channel],
      alt_q[attr_channel], burst_q[attr_channel]};
   dma_fifo #(.WIDTH(DW), .DEPTH(dma_channel_pkg::FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(mem_rdata),
      .out_valid(fifo_out_valid),
      .out_ready(mem_write && mem_ready),
      .out_data(fifo_out_data)
   );
endmodule

// ---- bench/dma_mem_model.sv ----
/* Memory partner of the DMA block: answers each request after slow stall cycles.
   Assumes one clock and a block that holds its request until ready. */
`timescale 1ns/1ps
module dma_mem_model (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Stall length.
   input wire logic [1:0] slow,
   // Memory side.
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ready,
   output logic [31:0] mem_rdata,
   // Seen writes.
   output logic [7:0] wr_cnt,
   output logic [31:0] last_addr,
   output logic [31:0] last_data
);
   logic [1:0] wait_q;
   assign mem_ready = mem_valid && (wait_q == slow);
   // Read data lives one cycle, then inverts every cycle, so stale data differs in the cycle after.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 2'h0;
         mem_rdata <= 32'h0;
         wr_cnt <= 8'h0;
         last_addr <= 32'h0;
         last_data <= 32'h0;
      end else begin
         wait_q <= (mem_valid && !mem_ready) ? wait_q + 2'h1 : 2'h0;
         mem_rdata <= (mem_ready && !mem_write) ? (mem_addr ^ 32'h5A5A_0000) : ~mem_rdata;
         if (mem_ready && mem_write) begin
            wr_cnt <= wr_cnt + 8'h1;
            last_addr <= mem_addr;
            last_data <= mem_wdata;
         end
      end
   end
endmodule

// ---- bench/dma_channel_control_checker.sv ----
/* Port checker of the DMA channel control block.
   Assumes one clock domain and the package compiled first. */
`timescale 1ns/1ps
module dma_channel_control_checker (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Watched ports.
   input wire logic [3:0] enable_set,
   input wire logic [3:0] enable_clear,
   input wire logic [3:0] enable_status,
   input wire logic [1:0] attr_channel,
   input wire logic attr_write,
   input wire logic [3:0] attr_value,
   input wire logic [3:0] attr_readback,
   input wire logic [1:0] mode_channel,
   input wire logic mode_alternate,
   input wire logic [2:0] mode_readback,
   input wire logic done_interrupt,
   input wire logic [3:0] peripheral_done,
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic mem_ready
);
   wire wr_acc = mem_valid && mem_write && mem_ready;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_no_move_off: assert property (mem_valid |-> enable_status != 4'h0)
      else $error("memory access with all channels disabled");
   a_done_clears_en: assert property (done_interrupt |-> !enable_status[3])
      else $error("software channel still enabled at completion");
   a_periph_clears_en: assert property (peripheral_done != 4'h0 |->
      (peripheral_done & enable_status) == 4'h0)
      else $error("peripheral channel still enabled at completion");
   a_set_enables: assert property (enable_set != 4'h0 && !wr_acc |=>
      (enable_status & $past(enable_set)) == $past(enable_set))
      else $error("enable set not seen in status");
   a_clear_disables: assert property (enable_clear != 4'h0 && enable_set == 4'h0 |=>
      (enable_status & $past(enable_clear)) == 4'h0)
      else $error("enable clear not seen in status");
   a_mode_stops: assert property (done_interrupt && mode_channel == 2'h3 && !mode_alternate
      |-> mode_readback == dma_channel_pkg::MODE_STOPPED)
      else $error("mode not stopped at completion");
   a_done_after_wr: assert property (done_interrupt |-> $past(wr_acc) && !peripheral_done[3])
      else $error("completion pulse without a final write");
   a_attr_held: assert property (attr_write ##1 attr_channel == $past(attr_channel)
      |-> attr_readback == $past(attr_value))
      else $error("attribute readback differs from written value");
endmodule
bind dma_channel_control dma_channel_control_checker chk_u (.mclk(mclk), .rst_b(rst_b),
   .enable_set(enable_set), .enable_clear(enable_clear), .enable_status(enable_status),
   .attr_channel(attr_channel), .attr_write(attr_write), .attr_value(attr_value),
   .attr_readback(attr_readback), .mode_channel(mode_channel),
   .mode_alternate(mode_alternate), .mode_readback(mode_readback),
   .done_interrupt(done_interrupt), .peripheral_done(peripheral_done),
   .mem_valid(mem_valid), .mem_write(mem_write), .mem_ready(mem_ready));

// ---- bench/tb_dma_channel_control.sv ----
/* Self-checking bench of the DMA channel control block and its FIFO.
   Assumes the memory model and checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_dma_channel_control;
   logic mclk = 0, rst_b = 0, aw = 0, sw = 0, alt = 0, gw = 0, flag = 0, malt = 0;
   logic [3:0] es = 0, ec = 0, sr = 0, pr = 0, av = 0, arb = 0, ar, pdone;
   logic [1:0] ac = 0, sc = 0, mc = 0, slow = 0;
   logic [2:0] sm = 0, mr;
   logic [31:0] src = 0, dst = 0, ma, mwd, mrd, la, ld;
   logic [10:0] cnt = 0;
   logic [7:0] wc, w0;
   logic [3:0] en;
   logic di, mv, mw, mrdy, rel;
   int error_cnt = 0, n_compared = 0, cyc = 0, rc = 0, r0 = 0;
   always #4 mclk = ~mclk;
   dma_channel_control dut_u (.mclk(mclk), .rst_b(rst_b), .enable_set(es), .enable_clear(ec),
      .enable_status(en), .software_request(sr), .peripheral_request(pr), .attr_channel(ac),
      .attr_write(aw), .attr_value(av), .attr_readback(ar), .setup_write(sw),
      .setup_channel(sc), .alternate_structure_select(alt), .setup_mode(sm), .setup_src(src),
      .setup_dst(dst), .setup_count(cnt), .setup_arb_log2(arb), .sg_write(gw),
      .task_list_start(src), .scatter_gather_task_count(cnt),
      .peripheral_scatter_gather_flag(flag), .mode_channel(mc), .mode_alternate(malt),
      .mode_readback(mr), .done_interrupt(di), .peripheral_done(pdone), .mem_valid(mv),
      .mem_write(mw), .mem_addr(ma), .mem_wdata(mwd), .mem_ready(mrdy), .mem_rdata(mrd),
      .arb_release(rel));
   dma_mem_model mem_u (.mclk(mclk), .rst_b(rst_b), .slow(slow), .mem_valid(mv),
      .mem_write(mw), .mem_addr(ma), .mem_wdata(mwd), .mem_ready(mrdy), .mem_rdata(mrd),
      .wr_cnt(wc), .last_addr(la), .last_data(ld));
   // *****
   // Helpers.
   // *****
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic setup(input logic [1:0] c, input logic a, input logic [2:0] m,
                        input logic [31:0] s, input logic [10:0] n);
      sc = c; alt = a; sm = m; src = s; dst = s + 32'h0000_0100; cnt = n; sw = 1;
      tick(1);
      sw = 0;
   endtask
   task automatic mode_is(input logic [1:0] c, input logic a, input logic [2:0] m);
      mc = c; malt = a;
      #1 `CHK(mr, m)
   endtask
   task automatic wait_done();
      int k;
      for (k = 0; k < 300 && !di && pdone == 4'h0; k++) tick(1);
      if (k == 300) `CHK(k, 0)
   endtask
   task end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // *****
   // Scenarios.
   // *****
   task automatic t_modes();
      logic [2:0] tbl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
      for (int i = 0; i < 6; i++) begin
         setup(2'h1, 1'b0, tbl[i], 32'h0, 11'h1);
         setup(2'h1, 1'b1, tbl[5 - i], 32'h0, 11'h1);
         mode_is(2'h1, 1'b0, tbl[i]);
         mode_is(2'h1, 1'b1, tbl[5 - i]);
      end
   endtask
   task automatic t_attr_sg();
      ac = 2'h2; av = 4'hA; aw = 1;
      tick(1);
      aw = 0;
      #1 `CHK(ar, 4'hA)
      ac = 2'h1;
      #1 `CHK(ar, 4'h0)
      for (int f = 0; f < 2; f++) begin
         sc = 2'h1; src = 32'h0000_0800; cnt = 11'h3; flag = f[0]; gw = 1;
         tick(1);
         gw = 0;
         mode_is(2'h1, 1'b0, f ? dma_channel_pkg::MODE_PERIPHERAL_SCATTER_GATHER
                              : dma_channel_pkg::MODE_MEMORY_SCATTER_GATHER);
      end
   endtask
   task automatic t_disabled();
      es = 4'h1;
      tick(1);
      es = 0; ec = 4'h1;
      `CHK(en[0], 1'b1)
      tick(1);
      ec = 0;
      `CHK(en[0], 1'b0)
      w0 = wc;
      setup(2'h0, 1'b0, dma_channel_pkg::MODE_BASIC_REQUEST, 32'h0000_0300, 11'h2);
      pr = 4'h1; sr = 4'h1;
      tick(1);
      sr = 0;
      tick(20);
      pr = 0;
      `CHK(wc, w0)
   endtask
   task automatic t_soft_auto();
      slow = 2'h2; w0 = wc;
      setup(2'h3, 1'b0, dma_channel_pkg::MODE_AUTO_COMPLETE, 32'h0000_0100, 11'h3);
      es = 4'h8;
      tick(1);
      es = 0; sr = 4'h8;
      tick(1);
      sr = 0; mc = 2'h3; malt = 0;
      wait_done();
      `CHK({di, pdone}, 5'h10)
      `CHK(en[3], 1'b0)
      `CHK(mr, dma_channel_pkg::MODE_STOPPED)
      `CHK(wc - w0, 8'h3)
      `CHK({la, ld}, {32'h0000_0208, 32'h5A5A_0108})
      tick(1);
      w0 = wc; sr = 4'h8;
      tick(1);
      sr = 0;
      tick(30);
      `CHK(wc, w0)
   endtask
   task automatic t_periph();
      slow = 2'h1; w0 = wc;
      setup(2'h0, 1'b0, dma_channel_pkg::MODE_BASIC_REQUEST, 32'h0000_0300, 11'h2);
      ac = 2'h0; av = 4'h8; aw = 1; es = 4'h1;
      tick(1);
      aw = 0; es = 0; pr = 4'h1;
      tick(20);
      `CHK(wc, w0)
      av = 4'h0; aw = 1;
      tick(1);
      aw = 0;
      wait_done();
      `CHK({di, pdone}, 5'h01)
      `CHK(en[0], 1'b0)
      `CHK(wc - w0, 8'h2)
      pr = 0;
   endtask
   task automatic t_fifo();
      slow = 2'h0; arb = 4'h1; w0 = wc; r0 = rc;
      setup(2'h2, 1'b1, dma_channel_pkg::MODE_AUTO_COMPLETE, 32'h0000_0400, 11'h5);
      es = 4'h4;
      tick(1);
      es = 0; sr = 4'h4;
      tick(1);
      sr = 0;
      wait_done();
      `CHK({di, pdone}, 5'h04)
      `CHK(en[2], 1'b0)
      `CHK(wc - w0, 8'h5)
      `CHK(rc - r0, 5)
      `CHK({la, ld}, {32'h0000_0510, 32'h5A5A_0410})
   endtask
   // *****
   // Sequence.
   // *****
   always @(posedge mclk) begin
      cyc++;
      if (rel) rc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      tick(10);
      rst_b = 1;
      tick(1);
      `CHK({en, ar, mr, di, pdone}, 16'h0)
      t_modes();
      t_attr_sg();
      t_disabled();
      t_soft_auto();
      t_periph();
      t_fifo();
      end_of_test();
   end
endmodule
